// [core/dpu_pkg.sv]
package dpu_pkg;

   // ****************************************************************
   // I/O port addresses and configuration indexes
   // ****************************************************************
   localparam logic [7:0] CFG_INDEX_PORT   = 8'hEC;
   localparam logic [7:0] CFG_DATA_PORT    = 8'hED;
   localparam logic [7:0] SYS_PORT_B       = 8'h61;
   localparam logic [7:0] IDX_DRAM_SETUP   = 8'h04;
   localparam logic [7:0] IDX_MISC_SETUP   = 8'h05;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SETUP_ILV_HI        = 7;
   localparam int SETUP_ILV_LO        = 5;
   localparam int SETUP_RTO_DIS       = 4;
   localparam int SETUP_WIDE_CFG      = 3;
   localparam int SETUP_DRV_HI        = 2;
   localparam int SETUP_DRV_LO        = 1;
   localparam int SETUP_PAGE_MODE     = 0;
   localparam int MISC_PAR_INHIBIT    = 2;
   localparam int PORTB_PAR_BIT       = 7;

   // ****************************************************************
   // Reset values and lane masks
   // ****************************************************************
   localparam logic [7:0] DRAM_SETUP_RST   = 8'h01;
   localparam logic [7:0] MISC_SETUP_RST   = 8'h00;
   localparam logic       REPORT_GATE_RST  = 1'b1;
   localparam logic [7:0] INDEX_RST        = 8'h00;
   localparam logic [7:0] READ_ZERO        = 8'h00;
   localparam logic [3:0] LANES_NONE       = 4'h0;
   localparam logic [3:0] LANES_ALL        = 4'hF;

   // ****************************************************************
   // Block state
   // ****************************************************************
   typedef struct packed {
      logic [7:0] index;
      logic [7:0] setup;
      logic [7:0] misc;
      logic       straps_done;
      logic       par_err;
      logic       report_gate;
      logic       nmi;
      logic [3:0] par_out;
      logic [3:0] par_oe;
      logic [7:0] rdata;
   } dpu_state_t;

endpackage

// [core/dpu_top.sv]
`timescale 1ns/1ps


module dpu_top
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic [7:0]  io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   output logic      [7:0]  io_rdata,
   input  wire logic        mem_valid,
   input  wire logic        mem_write,
   input  wire logic        mem_cpu,
   input  wire logic [3:0]  mem_byte_en,
   input  wire logic [31:0] mem_data,
   input  wire logic [3:0]  byte_parity_lines_in,
   output logic      [3:0]  byte_parity_lines_out,
   output logic      [3:0]  byte_parity_lines_oe,
   input  wire logic        boot_rom_strap,
   input  wire logic        peripheral_strap,
   input  wire logic        gate_a20_strap,
   output logic             parity_error,
   output logic             nmi_request,
   output logic      [2:0]  interleave_select,
   output logic             row_strobe_timeout_disable,
   output logic             wide_memory_config,
   output logic      [1:0]  address_drive_strength,
   output logic             page_mode_select,
   output logic             parity_check_inhibit
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Even parity bit for one byte: makes the nine-bit count even.
   function automatic logic even_par(input logic [7:0] b);
      even_par = ^b;
   endfunction

   // Generated parity for all four byte lanes of a word.
   function automatic logic [3:0] word_par(input logic [31:0] w);
      logic [3:0] p;
      p = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         p[i] = even_par(w[8*i +: 8]);
      end
      word_par = p;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   dpu_pkg::dpu_state_t st_r;
   dpu_pkg::dpu_state_t st_nxt;

   logic       inhibit;
   logic [3:0] gen_par;
   logic [3:0] lane_bad;
   logic       rd_err;
   logic       wr_data;
   logic       wr_index;
   logic       wr_portb;
   logic       clr_err;

   always_comb
   begin
      st_nxt   = st_r;
      inhibit  = st_r.misc[dpu_pkg::MISC_PAR_INHIBIT];
      gen_par  = word_par(mem_data);
      wr_data  = io_wr && (io_addr == dpu_pkg::CFG_DATA_PORT);
      wr_index = io_wr && (io_addr == dpu_pkg::CFG_INDEX_PORT);
      wr_portb = io_wr && (io_addr == dpu_pkg::SYS_PORT_B);

      // ****************************************************************
      // Strap capture after reset release
      // ****************************************************************
      // Straps are taken on the first enabled edge after release, since
      // an asynchronous reset may only load constants.
      if (!st_r.straps_done)
      begin
         st_nxt.straps_done = 1'b1;
         st_nxt.setup[dpu_pkg::SETUP_WIDE_CFG] = boot_rom_strap;
         st_nxt.setup[dpu_pkg::SETUP_DRV_HI]   = peripheral_strap;
         st_nxt.setup[dpu_pkg::SETUP_DRV_LO]   = gate_a20_strap;
      end

      // ****************************************************************
      // Configuration and port B writes
      // ****************************************************************
      if (wr_index)
      begin
         st_nxt.index = io_wdata;
      end
      if (wr_data && st_r.straps_done)
      begin
         unique case (st_r.index)
            dpu_pkg::IDX_DRAM_SETUP: st_nxt.setup = io_wdata;
            dpu_pkg::IDX_MISC_SETUP: st_nxt.misc  = io_wdata;
            default:                 st_nxt.index = st_r.index;
         endcase
      end
      clr_err = 1'b0;
      if (wr_portb)
      begin
         st_nxt.report_gate = io_wdata[dpu_pkg::PORTB_PAR_BIT];
         clr_err            = io_wdata[dpu_pkg::PORTB_PAR_BIT];
      end

      // ****************************************************************
      // Register reads
      // ****************************************************************
      if (io_rd)
      begin
         st_nxt.rdata = dpu_pkg::READ_ZERO;
         if (io_addr == dpu_pkg::CFG_INDEX_PORT)
         begin
            st_nxt.rdata = st_r.index;
         end
         else if (io_addr == dpu_pkg::CFG_DATA_PORT)
         begin
            unique case (st_r.index)
               dpu_pkg::IDX_DRAM_SETUP: st_nxt.rdata = st_r.setup;
               dpu_pkg::IDX_MISC_SETUP: st_nxt.rdata = st_r.misc;
               default:                 st_nxt.rdata = dpu_pkg::READ_ZERO;
            endcase
         end
         else if (io_addr == dpu_pkg::SYS_PORT_B)
         begin
            st_nxt.rdata[dpu_pkg::PORTB_PAR_BIT] = st_r.par_err;
         end
      end

      // ****************************************************************
      // Read checking
      // ****************************************************************
      // An enabled lane fails when its nine bits hold an odd count of ones.
      for (int i = 0; i < 4; i++)
      begin
         lane_bad[i] = mem_byte_en[i] &&
                       (even_par(mem_data[8*i +: 8]) !=
                        byte_parity_lines_in[i]);
      end
      rd_err = mem_valid && !mem_write && !inhibit &&
               (|lane_bad);

      // A new error outranks a clear written in the same cycle.
      if (rd_err)
      begin
         st_nxt.par_err = 1'b1;
      end
      else if (clr_err)
      begin
         st_nxt.par_err = 1'b0;
      end
      st_nxt.nmi = st_nxt.par_err && !st_nxt.report_gate;

      // ****************************************************************
      // Write parity drive
      // ****************************************************************
      st_nxt.par_out = dpu_pkg::LANES_NONE;
      st_nxt.par_oe  = dpu_pkg::LANES_NONE;
      if (mem_valid && mem_write && !mem_cpu)
      begin
         st_nxt.par_oe = dpu_pkg::LANES_ALL;
         // Zero parity lets diagnostics store deliberately bad parity.
         st_nxt.par_out = inhibit ? dpu_pkg::LANES_NONE : gen_par;
      end
      // CPU writes leave the lines released for the CPU's own parity.
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_r.index       <= dpu_pkg::INDEX_RST;
         st_r.setup       <= dpu_pkg::DRAM_SETUP_RST;
         st_r.misc        <= dpu_pkg::MISC_SETUP_RST;
         st_r.straps_done <= 1'b0;
         st_r.par_err     <= 1'b0;
         st_r.report_gate <= dpu_pkg::REPORT_GATE_RST;
         st_r.nmi         <= 1'b0;
         st_r.par_out     <= dpu_pkg::LANES_NONE;
         st_r.par_oe      <= dpu_pkg::LANES_NONE;
         st_r.rdata       <= dpu_pkg::READ_ZERO;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign io_rdata              = st_r.rdata;
   assign byte_parity_lines_out = st_r.par_out;
   assign byte_parity_lines_oe  = st_r.par_oe;
   assign parity_error          = st_r.par_err;
   assign nmi_request           = st_r.nmi;
   assign interleave_select     =
      st_r.setup[dpu_pkg::SETUP_ILV_HI:dpu_pkg::SETUP_ILV_LO];
   assign row_strobe_timeout_disable =
      st_r.setup[dpu_pkg::SETUP_RTO_DIS];
   assign wide_memory_config    = st_r.setup[dpu_pkg::SETUP_WIDE_CFG];
   assign address_drive_strength =
      st_r.setup[dpu_pkg::SETUP_DRV_HI:dpu_pkg::SETUP_DRV_LO];
   assign page_mode_select      = st_r.setup[dpu_pkg::SETUP_PAGE_MODE];
   assign parity_check_inhibit  = st_r.misc[dpu_pkg::MISC_PAR_INHIBIT];

endmodule

// [test/dpu_props.sv]
`timescale 1ns/1ps

module dpu_props
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        ce,
   input wire logic [7:0]  io_addr,
   input wire logic [7:0]  io_wdata,
   input wire logic        io_wr,
   input wire logic        mem_valid,
   input wire logic        mem_write,
   input wire logic        mem_cpu,
   input wire logic [3:0]  mem_byte_en,
   input wire logic [31:0] mem_data,
   input wire logic [3:0]  byte_parity_lines_in,
   input wire logic [3:0]  byte_parity_lines_out,
   input wire logic [3:0]  byte_parity_lines_oe,
   input wire logic        parity_error,
   input wire logic        nmi_request,
   input wire logic        parity_check_inhibit
);
   logic [3:0] gen, bad;
   logic       dma_wr, rd, pb_wr, gate_r;

   assign gen = {^mem_data[31:24], ^mem_data[23:16],
                 ^mem_data[15:8], ^mem_data[7:0]};
   assign bad = mem_byte_en & (byte_parity_lines_in ^ gen);
   assign dma_wr = mem_valid && mem_write && !mem_cpu;
   assign rd = mem_valid && !mem_write;
   assign pb_wr = ce && io_wr && io_addr == dpu_pkg::SYS_PORT_B;
   // Shadow of the report gate, which no port shows.
   always_ff @(posedge clk or posedge reset)
      gate_r <= reset ? 1'b1 : pb_wr ? io_wdata[7] : gate_r;

   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   dma_drive_a: assert property (
      dma_wr |=> byte_parity_lines_oe == 4'hF) else $error("Lines idle.");
   gen_parity_a: assert property (
      dma_wr && !parity_check_inhibit |=> byte_parity_lines_out == $past(gen))
      else $error("Bad parity driven.");
   inhibit_zero_a: assert property (
      dma_wr && parity_check_inhibit |=> byte_parity_lines_out == 4'h0)
      else $error("Inhibit parity not zero.");
   cpu_release_a: assert property (
      mem_valid && mem_write && mem_cpu |=> byte_parity_lines_oe == 4'h0)
      else $error("Lines driven on cpu write.");
   read_error_a: assert property (
      rd && !parity_check_inhibit && bad != 4'h0 |=> parity_error)
      else $error("Error missed.");
   no_false_a: assert property (
      rd && (parity_check_inhibit || bad == 4'h0) && !parity_error
      |=> !parity_error) else $error("False error.");
   sticky_err_a: assert property (
      parity_error && !(pb_wr && io_wdata[7]) |=> parity_error)
      else $error("Error lost.");
   nmi_level_a: assert property (
      nmi_request == (parity_error && !gate_r)) else $error("NMI wrong.");
endmodule

bind dpu_top dpu_props i_props (.*);

// [test/dpu_dram_model.sv]
`timescale 1ns/1ps

module dpu_dram_model
(
   input  wire logic [31:0] data,
   input  wire logic [3:0]  flip,
   input  wire logic        rd,
   output logic      [3:0]  par
);
   // Outside reads the lines float, so they show the inverse of parity.
   always_comb
      for (int i = 0; i < 4; i++)
         par[i] = (^data[8*i +: 8]) ^ (rd ? flip[i] : 1'b1);
endmodule

// [test/dram_parity_unit_tb.sv]
`timescale 1ns/1ps

module dram_parity_unit_tb;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
   logic mem_valid = 1'b0, mem_write = 1'b0, mem_cpu = 1'b0, inh = 1'b0;
   logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, v, pv;
   logic [3:0] mem_byte_en = 4'h0, flip = 4'h0, byte_parity_lines_in;
   logic [3:0] byte_parity_lines_out, byte_parity_lines_oe;
   logic [31:0] mem_data = 32'h0000_0000;
   logic [2:0] interleave_select, st;
   logic [1:0] address_drive_strength;
   logic boot_rom_strap, peripheral_strap, gate_a20_strap, rs, ws;
   logic parity_error, nmi_request, row_strobe_timeout_disable;
   logic wide_memory_config, page_mode_select, parity_check_inhibit;
   logic [7:0] q_rd[$], q_par[$];
   int mismatches = 0, cmp_count = 0;

   always #25 clk = ~clk;

   dpu_top i_dut (.*);
   dpu_dram_model i_mem (.data(mem_data), .flip(flip),
      .rd(mem_valid && !mem_write), .par(byte_parity_lines_in));

   function automatic logic [3:0] par(input logic [31:0] d);
      for (int i = 0; i < 4; i++)
         par[i] = ^d[8*i +: 8];
   endfunction

   task automatic chk(input logic [7:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp)
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      mismatches += int'(seen !== exp);
   endtask

   // Each task parks the other interface, so no strobe is written twice.
   task automatic io(input logic w, input logic [7:0] a, d);
      {mem_valid, io_wr, io_rd, io_addr, io_wdata} = {1'b0, w, !w, a, d};
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, e);
      q_rd.push_back(e);
      io(1'b0, a, 8'h00);
   endtask

   task automatic mem(input logic w, c, input logic [3:0] be, f,
                      input logic [31:0] d);
      {io_wr, io_rd} = 2'b00;
      {mem_valid, mem_write, mem_cpu, mem_byte_en, flip, mem_data} =
         {1'b1, w, c, be, f, d};
      if (w)
         q_par.push_back(c ? 8'h00 : {4'hF, inh ? 4'h0 : par(d)});
      @(negedge clk);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Results land one edge after their request; the oldest note is used.
   always @(posedge clk)
   begin
      rs = io_rd;
      ws = mem_valid && mem_write;
      #1;
      if (rs)
         chk(io_rdata, q_rd.pop_front(), "io_rdata");
      if (ws)
      begin
         pv = q_par.pop_front();
         chk({byte_parity_lines_oe, byte_parity_lines_out & pv[7:4]},
             pv, "parity_drive");
      end
   end

   initial
   begin
      void'($urandom(32'h6fd6_7a78));
      st = 3'($urandom);
      {boot_rom_strap, peripheral_strap, gate_a20_strap} = st;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      io(1'b1, 8'hEC, 8'h04);
      rd(8'hED, {4'h0, st, 1'b1});
      v = 8'($urandom);
      io(1'b1, 8'hED, v);
      rd(8'hED, v);
      chk({interleave_select, row_strobe_timeout_disable,
           wide_memory_config, address_drive_strength, page_mode_select},
          v, "setup_fields");
      io(1'b1, 8'hEC, 8'h07);
      rd(8'hED, 8'h00);
      repeat (4) mem(1'b1, 1'b0, 4'h0, 4'h0, $urandom);
      mem(1'b1, 1'b1, 4'hF, 4'h0, $urandom);
      mem(1'b0, 1'b0, 4'hF, 4'h0, $urandom);
      mem(1'b0, 1'b0, 4'h7, 4'h8, $urandom);
      rd(8'h61, 8'h00);
      mem(1'b0, 1'b0, 4'h4, 4'h4, $urandom);
      rd(8'h61, 8'h80);
      chk({7'h00, nmi_request}, 8'h00, "nmi_request");
      io(1'b1, 8'h61, 8'h00);
      chk({7'h00, nmi_request}, 8'h01, "nmi_request");
      io(1'b1, 8'h61, 8'h80);
      rd(8'h61, 8'h00);
      io(1'b1, 8'hEC, 8'h05);
      io(1'b1, 8'hED, 8'h04);
      inh = 1'b1;
      mem(1'b1, 1'b0, 4'h0, 4'h0, $urandom);
      mem(1'b0, 1'b0, 4'hF, 4'hF, $urandom);
      rd(8'h61, 8'h00);
      chk({7'h00, parity_check_inhibit}, 8'h01, "inhibit");
      ce = 1'b0;
      io(1'b1, 8'hED, 8'h00);
      ce = 1'b1;
      rd(8'hED, 8'h04);
      chk({7'h00, parity_check_inhibit}, 8'h01, "inhibit");
      print_verdict;
   end
endmodule
